// *** design/fdi_pkg.sv ***
// Shared constants, modes and carriers of the floppy drive interface
package fdi_pkg;
   // Timing, with the 25 MHz system clock
   localparam int CLK_NS      = 40;
   localparam int CELL_NS     = 4000;
   localparam int CELL_CYC    = CELL_NS / CLK_NS;
   localparam int HALF_CYC    = CELL_CYC / 2;
   localparam int WPULSE_NS   = 200;
   localparam int WPULSE_CYC  = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRECOMP_NS  = 125;
   localparam int PRECOMP_CYC = (PRECOMP_NS / CLK_NS < 1) ? 1 : PRECOMP_NS / CLK_NS;
   localparam int STEP_NS     = 1000;
   localparam int STEP_CYC    = (STEP_NS + CLK_NS - 1) / CLK_NS;

   // Counter widths and typed constants
   localparam int PH_W = 7;
   localparam int ST_W = 5;
   localparam int WP_W = 3;
   localparam int SR_W = 2 * PRECOMP_CYC + 1;
   localparam logic [PH_W-1:0] PH_ZERO = 7'h00;
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(CELL_CYC - 1);
   localparam logic [PH_W-1:0] PH_HALF = PH_W'(HALF_CYC);
   localparam logic [PH_W-1:0] PH_CMID = PH_W'(HALF_CYC / 2);
   localparam logic [PH_W-1:0] PH_DMID = PH_W'(HALF_CYC + HALF_CYC / 2);
   localparam logic [ST_W-1:0] ST_LOAD = ST_W'(STEP_CYC);
   localparam logic [WP_W-1:0] WP_LOAD = WP_W'(WPULSE_CYC);

   // Data word
   localparam int WORD_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [WORD_W-1:0] FILL_BYTE = 8'h00;
   localparam int SECTOR_BYTES_DEF = 256;
   localparam int BUF_DEPTH_DEF = 2;

   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_LEAD = 2'b01,
      W_DATA = 2'b10
   } wr_state_e;

   typedef enum logic {
      R_IDLE = 1'b0,
      R_RUN  = 1'b1
   } rd_state_e;

   typedef struct packed {
      logic sel_a;
      logic sel_b;
      logic motor;
      logic side_one;
   } drive_ctl_s;

   typedef struct packed {
      logic reading;
      logic writing;
      logic aborted;
      logic overrun;
      logic index_active;
      logic at_track_zero;
   } status_s;
endpackage : fdi_pkg

// *** design/floppy_drive_interface.sv ***
// Floppy drive interface: data separator, word assembly, MFM writer with precompensation, drive control
`timescale 1ns/1ps
module floppy_drive_interface #(
   parameter int SECTOR_BYTES = fdi_pkg::SECTOR_BYTES_DEF,
   parameter int BUF_DEPTH    = fdi_pkg::BUF_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // Host commands and drive settings
   input  wire logic                       cmd_read,
   input  wire logic                       cmd_write,
   input  wire logic                       cmd_step,
   input  wire logic                       step_toward_centre,
   input  wire fdi_pkg::drive_ctl_s        drive_ctl,
   // Write words from the host
   input  wire logic [fdi_pkg::WORD_W-1:0] wr_data,
   input  wire logic                       wr_valid,
   output logic                            wr_taken,
   // Read words to the host
   output logic [fdi_pkg::WORD_W-1:0]      rd_data,
   output logic                            rd_valid,
   input  wire logic                       rd_ready,
   // Events and status
   output logic                            irq,
   output fdi_pkg::status_s                status,
   // Drive inputs
   input  wire logic                       read_pulse_in,
   input  wire logic                       index_n,
   input  wire logic                       track_zero_n,
   input  wire logic                       write_protect_n,
   // Drive outputs
   output logic                            drive_a_select_n,
   output logic                            drive_b_select_n,
   output logic                            spindle_on_n,
   output logic                            step_dir,
   output logic                            step_pulse_n,
   output logic                            side_select_n,
   output logic                            write_pulse_out,
   output logic                            write_gate_n
);
   localparam int BC_W = $clog2(SECTOR_BYTES + 1);
   localparam logic [BC_W-1:0] BYTE_LAST = BC_W'(SECTOR_BYTES - 1);
   localparam int PC = fdi_pkg::PRECOMP_CYC;

   generate
      if (SECTOR_BYTES < 1 || BUF_DEPTH < 2) begin : g_bad
         $error("floppy_drive_interface needs SECTOR_BYTES >= 1 and BUF_DEPTH >= 2");
      end
   endgenerate

   // One-hot injection point in the precompensation shift register
   function automatic logic [fdi_pkg::SR_W-1:0] inject_at(input logic fire, input logic early, input logic late);
      logic [fdi_pkg::SR_W-1:0] v;
      v = '0;
      if (fire) begin
         if (early) v[0] = 1'b1;
         else if (late) v[2*PC] = 1'b1;
         else v[PC] = 1'b1;
      end
      return v;
   endfunction : inject_at

   // Read path state
   fdi_pkg::rd_state_e           rst_r, rst_nxt;
   logic [fdi_pkg::PH_W-1:0]     ph_r, ph_nxt;
   logic                         rd_prev_r, raw_read_r, raw_read_nxt, read_clock_r, read_clock_nxt;
   logic                         dbit_r, dbit_nxt, push_r, push_nxt, irq_r, irq_nxt;
   logic [fdi_pkg::WORD_W-1:0]   rsh_r, rsh_nxt, rword_r, rword_nxt;
   logic [2:0]                   rbit_r, rbit_nxt;
   logic [BC_W-1:0]              rbyte_r, rbyte_nxt;
   logic                         overrun_r, overrun_nxt, buf_in_ready;
   // Write path state
   fdi_pkg::wr_state_e           wst_r, wst_nxt;
   logic [fdi_pkg::PH_W-1:0]     wph_r, wph_nxt;
   logic [fdi_pkg::WORD_W-1:0]   wb_r, wb_nxt;
   logic [2:0]                   wbit_r, wbit_nxt;
   logic                         wprev_r, wprev_nxt, taken_r, taken_nxt, aborted_r, aborted_nxt;
   logic [BC_W-1:0]              wbyte_r, wbyte_nxt;
   logic [fdi_pkg::SR_W-1:0]     sr_r, sr_nxt, inj;
   logic [fdi_pkg::WP_W-1:0]     wp_cnt_r, wp_cnt_nxt;
   logic                         wpulse_r, wpulse_nxt, gate_n_r, gate_n_nxt;
   logic                         wcur, wnext, pc_early, pc_late;
   // Head and drive control state
   logic [fdi_pkg::ST_W-1:0]     st_cnt_r, st_cnt_nxt;
   logic                         step_n_r, step_n_nxt, dir_r, dir_nxt;
   fdi_pkg::drive_ctl_s          ctl_r;
   fdi_pkg::status_s             status_r, status_nxt;
   logic                         rd_edge, in_data_win, idle;

   assign idle        = (rst_r == fdi_pkg::R_IDLE) && (wst_r == fdi_pkg::W_IDLE);
   assign rd_edge     = read_pulse_in & ~rd_prev_r;
   assign in_data_win = (ph_r >= fdi_pkg::PH_HALF);
   assign wcur        = wb_r[wbit_r];
   assign wnext       = (wbit_r == fdi_pkg::BIT_FIRST) ? 1'b0 : wb_r[wbit_r - 3'h1];
   // A one is moved toward the neighbour that crowds it
   assign pc_early    = wprev_r & ~wnext;
   assign pc_late     = ~wprev_r & wnext;

   // Data separator and word assembly
   always_comb begin
      rst_nxt = rst_r;
      ph_nxt = (ph_r == fdi_pkg::PH_LAST) ? fdi_pkg::PH_ZERO : ph_r + 7'h01;
      raw_read_nxt = 1'b0;
      dbit_nxt = dbit_r;
      rsh_nxt = rsh_r;
      rword_nxt = rword_r;
      rbit_nxt = rbit_r;
      rbyte_nxt = rbyte_r;
      push_nxt = 1'b0;
      irq_nxt = 1'b0;
      overrun_nxt = overrun_r | (push_r & ~buf_in_ready);
      if (rst_r == fdi_pkg::R_IDLE) begin
         dbit_nxt = 1'b0;
         if (cmd_read && idle) begin
            rst_nxt = fdi_pkg::R_RUN;
            ph_nxt = fdi_pkg::PH_ZERO;
            rbit_nxt = '0;
            rbyte_nxt = '0;
            // A word lost on the start edge still counts, so the set wins over the clear
            overrun_nxt = push_r & ~buf_in_ready;
         end
      end else if (rd_edge) begin
         // Hard resync to the middle of the window the pulse fell in
         raw_read_nxt = 1'b1;
         dbit_nxt = dbit_r | in_data_win;
         ph_nxt = in_data_win ? fdi_pkg::PH_DMID : fdi_pkg::PH_CMID;
      end else if (ph_r == fdi_pkg::PH_LAST) begin
         rsh_nxt = {rsh_r[fdi_pkg::WORD_W-2:0], dbit_r};
         dbit_nxt = 1'b0;
         rbit_nxt = rbit_r + 3'h1;
         if (rbit_r == fdi_pkg::BIT_LAST) begin
            push_nxt = 1'b1;
            rword_nxt = {rsh_r[fdi_pkg::WORD_W-2:0], dbit_r};
            rbyte_nxt = rbyte_r + 1'b1;
            if (rbyte_r == BYTE_LAST) begin
               irq_nxt = 1'b1;
               rst_nxt = fdi_pkg::R_IDLE;
            end
         end
      end
      read_clock_nxt = (rst_nxt == fdi_pkg::R_RUN) && (ph_nxt >= fdi_pkg::PH_HALF);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_r <= fdi_pkg::R_IDLE;
         ph_r <= '0;
         rd_prev_r <= 1'b0;
         raw_read_r <= 1'b0;
         read_clock_r <= 1'b0;
         dbit_r <= 1'b0;
         rsh_r <= '0;
         rword_r <= '0;
         rbit_r <= '0;
         rbyte_r <= '0;
         push_r <= 1'b0;
         irq_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         rst_r <= rst_nxt;
         ph_r <= ph_nxt;
         rd_prev_r <= read_pulse_in;
         raw_read_r <= raw_read_nxt;
         read_clock_r <= read_clock_nxt;
         dbit_r <= dbit_nxt;
         rsh_r <= rsh_nxt;
         rword_r <= rword_nxt;
         rbit_r <= rbit_nxt;
         rbyte_r <= rbyte_nxt;
         push_r <= push_nxt;
         irq_r <= irq_nxt;
         overrun_r <= overrun_nxt;
      end
   end

   // The disk cannot be stalled, so a full buffer shows as overrun instead
   word_buffer #(.W(fdi_pkg::WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (push_r),
      .in_ready  (buf_in_ready),
      .in_data   (rword_r),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   // MFM writer
   always_comb begin
      wst_nxt = wst_r;
      wph_nxt = (wph_r == fdi_pkg::PH_LAST) ? fdi_pkg::PH_ZERO : wph_r + 7'h01;
      wb_nxt = wb_r;
      wbit_nxt = wbit_r;
      wprev_nxt = wprev_r;
      wbyte_nxt = wbyte_r;
      taken_nxt = 1'b0;
      aborted_nxt = aborted_r;
      inj = '0;
      case (wst_r)
         fdi_pkg::W_IDLE: begin
            if (cmd_write && idle) begin
               if (!write_protect_n) begin
                  aborted_nxt = 1'b1;
               end else begin
                  wst_nxt = fdi_pkg::W_LEAD;
                  wph_nxt = fdi_pkg::PH_ZERO;
                  wbyte_nxt = '0;
                  aborted_nxt = 1'b0;
               end
            end
         end
         fdi_pkg::W_LEAD: begin
            // One quiet cell with the gate on before the first pulse
            if (wph_r == fdi_pkg::PH_LAST) begin
               wst_nxt = fdi_pkg::W_DATA;
               wb_nxt = wr_valid ? wr_data : fdi_pkg::FILL_BYTE;
               taken_nxt = wr_valid;
               wbit_nxt = fdi_pkg::BIT_LAST;
               wprev_nxt = 1'b0;
            end
         end
         fdi_pkg::W_DATA: begin
            if (wph_r == fdi_pkg::PH_ZERO) begin
               inj = inject_at(~wprev_r & ~wcur, 1'b0, 1'b0);
            end else if (wph_r == fdi_pkg::PH_HALF) begin
               inj = inject_at(wcur, pc_early, pc_late);
            end else if (wph_r == fdi_pkg::PH_LAST) begin
               wprev_nxt = wcur;
               if (wbit_r == fdi_pkg::BIT_FIRST) begin
                  wbyte_nxt = wbyte_r + 1'b1;
                  if (wbyte_r == BYTE_LAST) begin
                     wst_nxt = fdi_pkg::W_IDLE;
                  end else begin
                     wb_nxt = wr_valid ? wr_data : fdi_pkg::FILL_BYTE;
                     taken_nxt = wr_valid;
                     wbit_nxt = fdi_pkg::BIT_LAST;
                  end
               end else begin
                  wbit_nxt = wbit_r - 3'h1;
               end
            end
         end
         default: wst_nxt = fdi_pkg::W_IDLE;
      endcase
      if (wst_r != fdi_pkg::W_IDLE && !write_protect_n) begin
         wst_nxt = fdi_pkg::W_IDLE;
         aborted_nxt = 1'b1;
      end
      sr_nxt = (sr_r >> 1) | inj;
      if (sr_r[0]) wp_cnt_nxt = fdi_pkg::WP_LOAD;
      else if (wp_cnt_r != '0) wp_cnt_nxt = wp_cnt_r - 3'h1;
      else wp_cnt_nxt = '0;
      // Pulses still in flight are dropped so none leaves with the gate off
      if (wst_nxt == fdi_pkg::W_IDLE) begin
         sr_nxt = '0;
         wp_cnt_nxt = '0;
      end
      wpulse_nxt = (wp_cnt_nxt != '0);
      gate_n_nxt = (wst_nxt == fdi_pkg::W_IDLE);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wst_r <= fdi_pkg::W_IDLE;
         wph_r <= '0;
         wb_r <= '0;
         wbit_r <= '0;
         wprev_r <= 1'b0;
         wbyte_r <= '0;
         taken_r <= 1'b0;
         aborted_r <= 1'b0;
         sr_r <= '0;
         wp_cnt_r <= '0;
         wpulse_r <= 1'b0;
         gate_n_r <= 1'b1;
      end else begin
         wst_r <= wst_nxt;
         wph_r <= wph_nxt;
         wb_r <= wb_nxt;
         wbit_r <= wbit_nxt;
         wprev_r <= wprev_nxt;
         wbyte_r <= wbyte_nxt;
         taken_r <= taken_nxt;
         aborted_r <= aborted_nxt;
         sr_r <= sr_nxt;
         wp_cnt_r <= wp_cnt_nxt;
         wpulse_r <= wpulse_nxt;
         gate_n_r <= gate_n_nxt;
      end
   end

   // Head stepping, drive selection and status
   always_comb begin
      dir_nxt = dir_r;
      st_cnt_nxt = (st_cnt_r != '0) ? st_cnt_r - 5'h01 : st_cnt_r;
      // Stepping outward past track zero is refused
      if (cmd_step && st_cnt_r == '0 && (step_toward_centre || track_zero_n)) begin
         dir_nxt = step_toward_centre;
         st_cnt_nxt = fdi_pkg::ST_LOAD;
      end
      step_n_nxt = (st_cnt_nxt == '0);
      status_nxt.reading = (rst_nxt == fdi_pkg::R_RUN);
      status_nxt.writing = (wst_nxt != fdi_pkg::W_IDLE);
      status_nxt.aborted = aborted_nxt;
      status_nxt.overrun = overrun_nxt;
      status_nxt.index_active = ~index_n;
      status_nxt.at_track_zero = ~track_zero_n;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_cnt_r <= '0;
         step_n_r <= 1'b1;
         dir_r <= 1'b0;
         ctl_r <= '1;
         status_r <= '0;
      end else begin
         st_cnt_r <= st_cnt_nxt;
         step_n_r <= step_n_nxt;
         dir_r <= dir_nxt;
         // Held inverted so each low-true pin leaves a flop directly
         ctl_r <= ~drive_ctl;
         status_r <= status_nxt;
      end
   end

   assign drive_a_select_n = ctl_r.sel_a;
   assign drive_b_select_n = ctl_r.sel_b;
   assign spindle_on_n     = ctl_r.motor;
   assign side_select_n    = ctl_r.side_one;
   assign step_dir         = dir_r;
   assign step_pulse_n     = step_n_r;
   assign write_pulse_out  = wpulse_r;
   assign write_gate_n     = gate_n_r;
   assign wr_taken         = taken_r;
   assign irq              = irq_r;
   assign status           = status_r;

   // Checks
   int unsigned step_low_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) step_low_q <= 0;
      else if (!step_n_r) step_low_q <= step_low_q + 1;
      else step_low_q <= 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_sep_resync: assert property (raw_read_r |-> (ph_r == fdi_pkg::PH_CMID || ph_r == fdi_pkg::PH_DMID))
      else $error("separator did not resync on a read pulse");
   a_word_push: assert property (push_r |-> ##1 (rd_valid && $past(rbit_r) == 3'h0))
      else $error("assembled word missing from the buffer");
   a_irq_sector: assert property (irq_r |-> ($past(push_nxt) && rst_r == fdi_pkg::R_IDLE))
      else $error("interrupt not tied to the last word of a sector");
   a_gate_lead: assert property ($fell(write_gate_n) |-> !write_pulse_out [*8])
      else $error("write pulse before the lead-in cell");
   a_precomp_early: assert property ((inj[0] && wph_r == fdi_pkg::PH_HALF) |=> sr_r[0] ##1 write_pulse_out)
      else $error("early shifted pulse not emitted");
   a_precomp_late: assert property ((inj[fdi_pkg::SR_W-1] && wph_r == fdi_pkg::PH_HALF)
                                    |-> ##7 (sr_r[0] || status.aborted))
      else $error("late shifted pulse not emitted");
   a_protect_abort: assert property ((!write_protect_n && !write_gate_n) |=> (write_gate_n && status.aborted))
      else $error("write not aborted on write protect");
   a_select_follow: assert property (##1 (drive_a_select_n == !$past(drive_ctl.sel_a)
                                      && drive_b_select_n == !$past(drive_ctl.sel_b)
                                      && spindle_on_n == !$past(drive_ctl.motor)))
      else $error("drive select or motor output wrong");
   a_step_dir: assert property ($fell(step_pulse_n) |-> step_dir == $past(step_toward_centre))
      else $error("step direction does not match command");
   a_step_width: assert property ($rose(step_pulse_n) |-> step_low_q == fdi_pkg::STEP_CYC)
      else $error("step pulse width wrong");
   a_dir_hold: assert property (!step_pulse_n |=> $stable(step_dir))
      else $error("direction changed during a step pulse");
   a_side_level: assert property (##1 (side_select_n == !$past(drive_ctl.side_one)))
      else $error("side select level wrong");
   a_pulse_gated: assert property (write_pulse_out |-> !write_gate_n)
      else $error("write pulse with the gate off");
   a_gate_idle: assert property ((wst_r == fdi_pkg::W_IDLE && !(cmd_write && idle)) |=> write_gate_n)
      else $error("write gate active with no write");

   c_sector_read: cover property (irq_r);
   c_write_abort: cover property (!write_gate_n ##1 status.aborted);
   c_step_done: cover property ($rose(step_pulse_n));
   c_buffer_full: cover property (push_r && !buf_in_ready);
   c_data_bit: cover property (raw_read_r && read_clock_r);
endmodule : floppy_drive_interface

// *** design/word_buffer.sv ***
// Small shift-register FIFO whose head entry is the output register
`timescale 1ns/1ps
module word_buffer #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int CW = $clog2(DEPTH + 1);

   generate
      if (DEPTH < 2 || W < 1) begin : g_bad
         $error("word_buffer needs DEPTH >= 2 and W >= 1");
      end
   endgenerate

   logic [W-1:0]  mem_r   [DEPTH];
   logic [W-1:0]  mem_nxt [DEPTH];
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          valid_r;
   logic          valid_nxt;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != CW'(DEPTH));
   assign push      = in_valid & in_ready;
   assign pop       = valid_r & out_ready;
   assign out_valid = valid_r;
   assign out_data  = mem_r[0];

   always_comb begin
      int idx;
      idx = int'(cnt_r);
      mem_nxt = mem_r;
      cnt_nxt = cnt_r;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            mem_nxt[i] = mem_r[i+1];
         end
         idx = idx - 1;
      end
      // Push lands after the pop shift, but a full buffer takes no word even while it drains
      if (push) begin
         mem_nxt[idx] = in_data;
      end
      cnt_nxt = CW'(idx + (push ? 1 : 0));
      valid_nxt = (cnt_nxt != '0);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
         cnt_r   <= '0;
         valid_r <= 1'b0;
      end else begin
         mem_r   <= mem_nxt;
         cnt_r   <= cnt_nxt;
         valid_r <= valid_nxt;
      end
   end
endmodule : word_buffer

// *** testbench/drive_model.sv ***
// Behavioural mini floppy drive: head position, index, protect and MFM read stream
`timescale 1ns/1ps
module drive_model (
   // Clock
   input  wire logic       clk,
   // Bench control
   input  wire logic       start,
   input  wire logic [7:0] pattern,
   input  wire logic       protect,
   // Drive lines
   input  wire logic       step_pulse_n,
   input  wire logic       step_dir,
   output logic            read_pulse_in,
   output logic            index_n,
   output logic            track_zero_n,
   output logic            write_protect_n
);
   int   track = 0;
   int   cyc   = -1;
   int   tick  = 0;
   int   ph;
   logic cur;
   logic prv;
   logic go = 1'b0;
   // Start is taken on the rising edge, where the bench holds it still
   always @(posedge clk) go <= start;
   // Head moves when the pulse ends, so the direction set with the pulse is settled
   always @(posedge step_pulse_n) track <= step_dir ? track + 1 : (track > 0 ? track - 1 : 0);
   // Sixteen cells are sent after start, then the line stays low
   always @(negedge clk) begin
      tick <= tick + 1;
      cyc  <= go ? 0 : ((cyc >= 0 && cyc < 1599) ? cyc + 1 : -1);
   end
   always_comb begin
      cur = pattern[3'(7 - (cyc / 100) % 8)];
      prv = (cyc < 100) ? 1'b0 : pattern[3'(7 - (cyc / 100 - 1) % 8)];
      ph  = cyc % 100;
      read_pulse_in = (cyc >= 0) && ((cur && ph inside {[75:76]}) || (!cur && !prv && ph inside {[25:26]}));
   end
   assign index_n         = (tick % 5000) >= 20;
   assign track_zero_n    = track != 0;
   assign write_protect_n = !protect;
endmodule : drive_model

// *** testbench/floppy_drive_interface_tb.sv ***
// Self-checking bench of the floppy drive interface
`timescale 1ns/1ps
module floppy_drive_interface_tb;
   logic clk = 0, nrst = 0, cmd_read = 0, cmd_write = 0, cmd_step = 0, dir = 0;
   logic wr_valid = 0, rd_ready = 0, start = 0, protect = 0;
   logic [7:0] wr_data = 8'h00, pattern = 8'h00, rd_data;
   fdi_pkg::drive_ctl_s ctl = 4'h0;
   fdi_pkg::status_s status;
   logic wr_taken, rd_valid, irq, a_n, b_n, mot_n, sdir, step_n, side_n, wpulse, gate_n, rpulse, idx_n, tz_n, wp_n;
   int err_total = 0, checked = 0, tick = 0;
   always #20 clk = ~clk;
   floppy_drive_interface #(.SECTOR_BYTES(2), .BUF_DEPTH(2)) i_dut (.clk(clk), .nrst(nrst), .cmd_read(cmd_read),
      .cmd_write(cmd_write), .cmd_step(cmd_step), .step_toward_centre(dir), .drive_ctl(ctl), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_taken(wr_taken), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .irq(irq), .status(status), .read_pulse_in(rpulse), .index_n(idx_n), .track_zero_n(tz_n),
      .write_protect_n(wp_n), .drive_a_select_n(a_n), .drive_b_select_n(b_n), .spindle_on_n(mot_n),
      .step_dir(sdir), .step_pulse_n(step_n), .side_select_n(side_n), .write_pulse_out(wpulse),
      .write_gate_n(gate_n));
   drive_model i_drive (.clk(clk), .start(start), .pattern(pattern), .protect(protect), .step_pulse_n(step_n),
      .step_dir(sdir), .read_pulse_in(rpulse), .index_n(idx_n), .track_zero_n(tz_n), .write_protect_n(wp_n));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc_n(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc_n
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic rd_sector(input logic [7:0] pat);
      int n;
      n = 0;
      pattern = pat; cmd_read = 1; start = 1;
      cyc_n(1);
      cmd_read = 0; start = 0;
      chk("reading", 1, status.reading);
      while (irq !== 1'b1 && n < 2000) begin cyc_n(1); n++; end
      chk("irq", 1, irq);
   endtask : rd_sector
   // Second sector arrives while the host stalls, so its words must be dropped, not the first ones
   task automatic t_read;
      int n;
      rd_sector(8'ha5);
      chk("overrun", 0, status.overrun);
      rd_sector(8'h3c);
      chk("overrun", 1, status.overrun);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (rd_valid !== 1'b1 && n < 10) begin cyc_n(1); n++; end
         chk("rd_data", 8'ha5, rd_data);
         rd_ready = 1;
         cyc_n(1);
         rd_ready = 0;
         cyc_n(1);
      end
      cyc_n(2);
      chk("rd_valid", 0, rd_valid);
      chk("reading", 0, status.reading);
      chk("index", 0, status.index_active);
      $display("t_read done");
   endtask : t_read
   // Bytes ff then 00: eight data pulses, then seven clock pulses after the first zero
   task automatic t_write;
      int n, pulses, taken;
      logic last;
      n = 0; pulses = 0; taken = 0; last = 0;
      wr_data = 8'hff; wr_valid = 1; cmd_write = 1;
      cyc_n(1);
      cmd_write = 0;
      chk("gate_n", 0, gate_n);
      while (n < 2100) begin
         cyc_n(1);
         n++;
         if (wpulse === 1'b1 && !last) pulses++;
         last = wpulse;
         if (wr_taken === 1'b1) begin taken++; wr_data = 8'h00; wr_valid = taken < 2; end
      end
      chk("pulses", 15, pulses);
      chk("taken", 2, taken);
      chk("gate_n", 1, gate_n);
      chk("writing", 0, status.writing);
      $display("t_write done");
   endtask : t_write
   task automatic t_protect;
      protect = 1; cmd_write = 1;
      cyc_n(1);
      cmd_write = 0;
      cyc_n(2);
      chk("gate_n", 1, gate_n);
      chk("aborted", 1, status.aborted);
      protect = 0; cmd_write = 1;
      cyc_n(1);
      cmd_write = 0;
      chk("aborted", 0, status.aborted);
      cyc_n(300);
      chk("gate_n", 0, gate_n);
      protect = 1;
      cyc_n(1);
      chk("gate_n", 1, gate_n);
      cyc_n(5);
      chk("aborted", 1, status.aborted);
      chk("writing", 0, status.writing);
      protect = 0;
      $display("t_protect done");
   endtask : t_protect
   task automatic step_once(input logic d, output int low);
      low = 0;
      dir = d; cmd_step = 1;
      cyc_n(1);
      cmd_step = 0;
      chk("step_dir", d, sdir);
      while (step_n === 1'b0 && low < 100) begin cyc_n(1); low++; end
      cyc_n(4);
   endtask : step_once
   task automatic t_step;
      int low;
      step_once(1, low);
      chk("step_low", 8'(fdi_pkg::STEP_CYC), 8'(low));
      chk("track_zero", 0, status.at_track_zero);
      step_once(0, low);
      chk("track_zero", 1, status.at_track_zero);
      step_once(0, low);
      chk("step_low", 0, 8'(low));
      $display("t_step done");
   endtask : t_step
   always @(posedge clk) begin
      tick++;
      if (tick == 12000) begin
         err_total++;
         close_out();
      end
   end
   task automatic t_reset;
      cyc_n(3);
      chk("reset", 8'h0f, {gate_n, step_n, a_n, side_n});
      cyc_n(3);
      nrst = 1;
      $display("t_reset done");
   endtask : t_reset
   // Index is low for the first 20 cycles of the run, so it shows right after reset
   task automatic t_drive;
      ctl = 4'b1010;
      cyc_n(2);
      chk("drive", 8'h05, {a_n, b_n, mot_n, side_n});
      chk("index", 1, status.index_active);
      ctl = 4'b0101;
      cyc_n(2);
      chk("drive", 8'h0a, {a_n, b_n, mot_n, side_n});
      $display("t_drive done");
   endtask : t_drive
   initial begin
      t_reset();
      t_drive();
      t_read();
      t_write();
      t_protect();
      t_step();
      close_out();
   end
endmodule : floppy_drive_interface_tb
